//--- sim/baud_gen_tb.sv
// self-checking bench for the bit-rate generator and its register access
`timescale 1ns/1ps
module baud_gen_tb;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic tx_shift_empty, bit_tick;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] rx_flags;
   logic [3:0] tick_count;
   logic [7:0] tx_ctrl, rx_ctrl;
   logic err;
   logic [31:0] gap;
   int fail_count, compares;
   logic [3:0] t0;
   // entries 0 and 2 give one rate at low and at high speed
   logic [7:0] tx_tab [6] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h90, 8'h94};
   logic [7:0] div_tab [6] = '{8'h00, 8'h02, 8'h03, 8'hFF, 8'h00, 8'h05};

   baud_gen DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_shift_empty(tx_shift_empty), .rx_flags(rx_flags),
      .tx_ctrl(tx_ctrl), .rx_ctrl(rx_ctrl), .bit_tick(bit_tick));
   shift_model partner (.pclk(pclk), .presetn(presetn), .bit_tick(bit_tick),
      .tx_shift_empty(tx_shift_empty), .rx_flags(rx_flags), .tick_count(tick_count));

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic end_of_test;
      $display("mismatches %0d of %0d compares", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // an edge passes first so a back-to-back call never reassigns psel in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // edges from now until the tick is seen settled at the following low phase
   task automatic first_tick(output logic [31:0] g);
      g = 0;
      do
      begin
         @(posedge pclk);
         g++;
         @(negedge pclk);
      end
      while (bit_tick !== 1'b1 && g < 20000);
   endtask : first_tick

   task automatic check_reset;
      apb(1'b0, baud_pkg::TX_CTRL_ADDR, 32'h0000_0000);
      check(rd, 32'h0000_0002);
      apb(1'b0, baud_pkg::RX_CTRL_ADDR, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b0, baud_pkg::DIVISOR_ADDR, 32'h0000_0000);
      check(rd, 32'h0000_0000);
   endtask : check_reset

   task automatic do_reset;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   function automatic logic [31:0] period(input logic [7:0] tx, input logic [7:0] dv);
      logic [31:0] p;
      p = tx[4] ? 32'h0000_0004 : (tx[2] ? 32'h0000_0010 : 32'h0000_0040);
      return p * ({24'h00_0000, dv} + 32'h0000_0001);
   endfunction : period

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      fail_count = 0;
      compares = 0;
      do_reset;
      check_reset;
      apb(1'b0, 12'h100, 32'h0000_0000);
      check({rd[31:1], err}, 32'h0000_0001);
      // sync slave: no ticks, so the status copies are steady while read
      apb(1'b1, baud_pkg::TX_CTRL_ADDR, 32'h0000_007F);
      apb(1'b1, baud_pkg::RX_CTRL_ADDR, 32'h0000_00FF);
      repeat (300) @(posedge pclk);
      check({28'h000_0000, tick_count}, 32'h0000_0000);
      apb(1'b0, baud_pkg::TX_CTRL_ADDR, 32'h0000_0000);
      check(rd, {24'h00_0000, 8'h75 | {6'h00, tx_shift_empty, 1'b0}});
      check({24'h00_0000, tx_ctrl}, {24'h00_0000, 8'h75 | {6'h00, tx_shift_empty, 1'b0}});
      apb(1'b0, baud_pkg::RX_CTRL_ADDR, 32'h0000_0000);
      check(rd, {24'h00_0000, 8'hF8 | {5'h00, rx_flags}});
      check({24'h00_0000, rx_ctrl}, {24'h00_0000, 8'hF8 | {5'h00, rx_flags}});
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, baud_pkg::TX_CTRL_ADDR, {24'h00_0000, tx_tab[i]});
         apb(1'b1, baud_pkg::DIVISOR_ADDR, {24'h00_0000, div_tab[i]});
         apb(1'b0, baud_pkg::DIVISOR_ADDR, 32'h0000_0000);
         check(rd, {24'h00_0000, div_tab[i]});
         first_tick(gap);
         // the partner counts one step per tick; a wide tick would count twice
         t0 = tick_count;
         first_tick(gap);
         check(gap, period(tx_tab[i], div_tab[i]));
         check({28'h000_0000, 4'(tick_count - t0)}, 32'h0000_0001);
      end
      // a long count is cut short by the next divisor write
      apb(1'b1, baud_pkg::TX_CTRL_ADDR, 32'h0000_0090);
      apb(1'b1, baud_pkg::DIVISOR_ADDR, 32'h0000_00C8);
      repeat (100) @(posedge pclk);
      apb(1'b1, baud_pkg::DIVISOR_ADDR, 32'h0000_0001);
      first_tick(gap);
      // the first tick follows a full period counted from the commit edge
      check(gap, period(8'h90, 8'h01));
      @(posedge pclk);
      do_reset;
      check_reset;
      end_of_test;
   end

   initial
   begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      end_of_test;
   end
endmodule : baud_gen_tb

//--- sim/shift_model.sv
// behavioural model of the serial shift logic that consumes the bit-rate tick
`timescale 1ns/1ps
module shift_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic bit_tick,
   output logic tx_shift_empty,
   output logic [2:0] rx_flags,
   output logic [3:0] tick_count
);
   ////////////////////////////////////////////////////////////////////////////////
   // one shift step per tick; a wide tick would count twice
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_count <= 4'h0;
      else if (bit_tick)
         tick_count <= tick_count + 4'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // status levels move with each step so the copied bits cannot stay stuck
   assign tx_shift_empty = ~tick_count[0];
   assign rx_flags = tick_count[3:1];
endmodule : shift_model

//--- verilog/baud_gen.sv
// serial port bit-rate generator with apb register access
//
// Functional notes
// - async, low speed: rate is clock over 64 times divisor plus one
// - async, high speed: rate is clock over 16 times divisor plus one
// - sync mode: rate is clock over 4 times divisor plus one
// - any divisor write restarts the timer at once
// - divisor is one unsigned 8-bit register, 0 to 255
// - reset values: tx control 0x02, rx control 0x00, divisor 0x00
// - divisor sets reload period of a free-running 8-bit timer
// - sync mode ignores the high-speed select
// - always ticks in async mode; in sync mode ticks only when the port is clock master
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module baud_gen
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_shift_empty,
   input wire logic [2:0] rx_flags,
   output logic [7:0] tx_ctrl,
   output logic [7:0] rx_ctrl,
   output logic bit_tick
);
   logic [7:0] tx_ctrl_reg;
   logic [7:0] rx_ctrl_reg;
   logic [7:0] baud_divisor_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic bit_tick_reg;
   logic setup;
   logic commit;
   logic wr_tx;
   logic wr_rx;
   logic wr_div;
   logic sync_mode;
   logic high_speed_select;
   logic master;
   logic [6:0] prescale;
   logic expire;

   assign setup = psel && !penable && !pready_reg;
   assign commit = psel && penable && pready_reg;
   assign wr_tx = commit && pwrite && (paddr == baud_pkg::TX_CTRL_ADDR);
   assign wr_rx = commit && pwrite && (paddr == baud_pkg::RX_CTRL_ADDR);
   assign wr_div = commit && pwrite && (paddr == baud_pkg::DIVISOR_ADDR);

   assign sync_mode = tx_ctrl_reg[baud_pkg::TX_SYNC_BIT];
   assign high_speed_select = tx_ctrl_reg[baud_pkg::TX_HIGH_SPEED_SELECT_BIT];
   // async always generates its own clock; sync only as clock master
   assign master = !sync_mode || tx_ctrl_reg[baud_pkg::TX_CLK_MASTER_BIT];
   assign prescale = baud_pkg::prescale_of(sync_mode, high_speed_select);

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign tx_ctrl = tx_ctrl_reg;
   assign rx_ctrl = rx_ctrl_reg;
   assign bit_tick = bit_tick_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // apb handshake: one wait-free access, data latched in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else if (ce)
      begin
         pready_reg <= setup;
         if (setup)
         begin
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            case (paddr)
               baud_pkg::TX_CTRL_ADDR: prdata_reg <= {24'h00_0000, tx_ctrl_reg};
               baud_pkg::RX_CTRL_ADDR: prdata_reg <= {24'h00_0000, rx_ctrl_reg};
               baud_pkg::DIVISOR_ADDR: prdata_reg <= {24'h00_0000, baud_divisor_reg};
               default: pslverr_reg <= 1'b1;
            endcase
         end
         else if (commit)
            pslverr_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tx_ctrl_reg <= baud_pkg::TX_CTRL_RESET;
      else if (ce)
      begin
         if (wr_tx)
            tx_ctrl_reg <= (pwdata[7:0] & baud_pkg::TX_CTRL_WMASK)
               | (tx_ctrl_reg & ~baud_pkg::TX_CTRL_WMASK);
         // shift-empty status follows the transmitter every cycle
         tx_ctrl_reg[baud_pkg::TX_SHIFT_EMPTY_BIT] <= tx_shift_empty;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rx_ctrl_reg <= baud_pkg::RX_CTRL_RESET;
      else if (ce)
      begin
         if (wr_rx)
            rx_ctrl_reg[7:3] <= pwdata[7:3];
         rx_ctrl_reg[2:0] <= rx_flags;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         baud_divisor_reg <= baud_pkg::DIVISOR_RESET;
      else if (ce && wr_div)
         baud_divisor_reg <= pwdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // restart uses the written value directly so the new rate starts now
   bit_rate_timer u_timer
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .restart(wr_div),
      .run(master),
      .prescale_last(6'(prescale - 7'h01)),
      .load(wr_div ? pwdata[7:0] : baud_divisor_reg),
      .expire(expire)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bit_tick_reg <= 1'b0;
      else if (ce)
         bit_tick_reg <= expire && master;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helper: cycles since last tick, valid only with settings untouched
   logic [14:0] gap_cnt;
   logic gap_valid;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_cnt <= 15'h0000;
         gap_valid <= 1'b0;
      end
      else if (ce)
      begin
         gap_cnt <= bit_tick_reg ? 15'h0001 : gap_cnt + 15'h0001;
         if (commit || !master)
            gap_valid <= 1'b0;
         else if (bit_tick_reg)
            gap_valid <= 1'b1;
      end
   end

   sequence s_settled_tick;
      ce && bit_tick_reg && gap_valid && !commit;
   endsequence

   property p_async_low;
      @(posedge pclk) disable iff (!presetn)
      (s_settled_tick and (!sync_mode && !high_speed_select)) |->
         gap_cnt == ({7'h00, baud_divisor_reg} + 15'h0001)
            * 15'(baud_pkg::PRESCALE_ASYNC_LOW);
   endproperty
   a_async_low: assert property (p_async_low)
      else $error("async low-speed tick period wrong");

   property p_async_high;
      @(posedge pclk) disable iff (!presetn)
      (s_settled_tick and (!sync_mode && high_speed_select)) |->
         gap_cnt == ({7'h00, baud_divisor_reg} + 15'h0001)
            * 15'(baud_pkg::PRESCALE_ASYNC_HIGH);
   endproperty
   a_async_high: assert property (p_async_high)
      else $error("async high-speed tick period wrong");

   property p_sync;
      @(posedge pclk) disable iff (!presetn)
      (s_settled_tick and sync_mode) |->
         gap_cnt == ({7'h00, baud_divisor_reg} + 15'h0001)
            * 15'(baud_pkg::PRESCALE_SYNC);
   endproperty
   a_sync: assert property (p_sync)
      else $error("sync tick period wrong");

   property p_sync_prescale;
      @(posedge pclk) disable iff (!presetn)
      sync_mode |-> prescale == baud_pkg::PRESCALE_SYNC;
   endproperty
   a_sync_prescale: assert property (p_sync_prescale)
      else $error("sync prescale depends on high-speed select");

   property p_divisor_write;
      @(posedge pclk) disable iff (!presetn)
      (ce && wr_div) |=> baud_divisor_reg == $past(pwdata[7:0]) ##1 !bit_tick_reg;
   endproperty
   a_divisor_write: assert property (p_divisor_write)
      else $error("divisor write not taken or tick not restarted");

   property p_reset_values;
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (tx_ctrl_reg[7:2] == 6'h00 && baud_divisor_reg == 8'h00
         && rx_ctrl_reg[7:3] == 5'h00);
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("register reset value wrong");

   property p_slave_silent;
      @(posedge pclk) disable iff (!presetn)
      (ce && !master) [*2] |-> !bit_tick_reg;
   endproperty
   a_slave_silent: assert property (p_slave_silent)
      else $error("tick produced as synchronous slave");

   property p_tick_single;
      @(posedge pclk) disable iff (!presetn)
      // the shortest period is four cycles, so two ticks in a row are never legal
      (ce && bit_tick_reg) ##1 ce |-> !bit_tick_reg;
   endproperty
   a_tick_single: assert property (p_tick_single)
      else $error("tick wider than one cycle");
endmodule : baud_gen

//--- verilog/baud_pkg.sv
// shared constants and decode helpers for the serial bit-rate generator
package baud_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [9:0] RX_CTRL_INDEX = 10'h018;
   localparam logic [9:0] TX_CTRL_INDEX = 10'h098;
   localparam logic [9:0] DIVISOR_INDEX = 10'h099;
   localparam logic [11:0] RX_CTRL_ADDR = {RX_CTRL_INDEX, 2'b00};
   localparam logic [11:0] TX_CTRL_ADDR = {TX_CTRL_INDEX, 2'b00};
   localparam logic [11:0] DIVISOR_ADDR = {DIVISOR_INDEX, 2'b00};

   // reset values
   localparam logic [7:0] TX_CTRL_RESET = 8'h02;
   localparam logic [7:0] RX_CTRL_RESET = 8'h00;
   localparam logic [7:0] DIVISOR_RESET = 8'h00;

   // writable bits; the rest are status or read as zero
   localparam logic [7:0] TX_CTRL_WMASK = 8'hF5;
   localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;

   // field positions in the transmit control register
   localparam int TX_CLK_MASTER_BIT = 7;
   localparam int TX_SYNC_BIT = 4;
   localparam int TX_HIGH_SPEED_SELECT_BIT = 2;
   localparam int TX_SHIFT_EMPTY_BIT = 1;

   // prescale factors per mode
   localparam logic [6:0] PRESCALE_ASYNC_LOW = 7'h40;
   localparam logic [6:0] PRESCALE_ASYNC_HIGH = 7'h10;
   localparam logic [6:0] PRESCALE_SYNC = 7'h04;

   // prescale factor: sync mode ignores the high-speed select
   function automatic logic [6:0] prescale_of(input logic sync, input logic hs);
      if (sync)
         prescale_of = PRESCALE_SYNC;
      else if (hs)
         prescale_of = PRESCALE_ASYNC_HIGH;
      else
         prescale_of = PRESCALE_ASYNC_LOW;
   endfunction : prescale_of

   // clock cycles between two bit-rate ticks
   function automatic logic [14:0] period_of(input logic sync, input logic hs,
                                             input logic [7:0] div);
      // widen before the product so 64 times 256 does not wrap
      period_of = 15'(prescale_of(sync, hs)) * (15'(div) + 15'h0001);
   endfunction : period_of
endpackage : baud_pkg

//--- verilog/bit_rate_timer.sv
// prescaler and 8-bit reload timer that paces the bit-rate tick
`timescale 1ns/1ps
module bit_rate_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic restart,
   input wire logic run,
   input wire logic [5:0] prescale_last,
   input wire logic [7:0] load,
   output logic expire
);
   logic [5:0] pre_reg;
   logic [7:0] cnt_reg;
   logic pre_done;

   // >= so a mode change to a shorter prescale never overshoots
   assign pre_done = (pre_reg >= prescale_last);
   assign expire = run && !restart && pre_done && (cnt_reg == 8'h00);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_reg <= 6'h00;
         cnt_reg <= 8'h00;
      end
      else if (ce)
      begin
         if (restart || !run)
         begin
            pre_reg <= 6'h00;
            cnt_reg <= load;
         end
         else if (pre_done)
         begin
            pre_reg <= 6'h00;
            cnt_reg <= (cnt_reg == 8'h00) ? load : cnt_reg - 8'h01;
         end
         else
            pre_reg <= pre_reg + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_restart_clears;
      @(posedge pclk) disable iff (!presetn)
      (ce && restart) |=> (pre_reg == 6'h00 && cnt_reg == $past(load));
   endproperty
   a_restart_clears: assert property (p_restart_clears)
      else $error("timer not cleared by divisor write");

   property p_count_bounded;
      @(posedge pclk) disable iff (!presetn)
      // compare with the reload seen when the count was updated, not a new write
      (ce && run && !restart && $stable(load)) |=> (cnt_reg <= $past(load));
   endproperty
   a_count_bounded: assert property (p_count_bounded)
      else $error("timer count above reload value");
endmodule : bit_rate_timer
